/* spi_cfg_pkg.sv */
// Purpose: Shared constants and types for the serial flash configuration and status block.
// Assumes: 8-bit register port with byte offsets, 10 MHz ref_clk.
// Notes:   Every offset, field position, reset value and timing count is named here once.
package spi_cfg_pkg;

   // Register offsets on the 8-bit address port.
   localparam logic [7:0] OFF_CONTROL  = 8'hF0;
   localparam logic [7:0] OFF_TIMEOUT  = 8'hF1;
   localparam logic [7:0] OFF_DIVISOR  = 8'hF2;
   localparam logic [7:0] OFF_STATUS   = 8'hF3;
   localparam logic [7:0] OFF_TX_DATA  = 8'hE0;
   localparam logic [7:0] OFF_RX_DATA  = 8'hE1;
   localparam logic [7:0] OFF_EV_STAT  = 8'hE4;
   localparam logic [7:0] OFF_EV_CLEAR = 8'hE5;
   localparam logic [7:0] OFF_EV_EN    = 8'hE6;

   // Serial status bit positions.
   localparam int ST_DONE    = 7;
   localparam int ST_HUB     = 6;
   localparam int ST_ENABLE  = 5;
   localparam int ST_PRIMARY = 4;
   localparam int ST_BUSY    = 3;

   // Event register bit positions.
   localparam int EV_DONE    = 0;
   localparam int EV_HUB     = 1;
   localparam int EV_PRIMARY = 2;
   localparam int EV_W       = 3;

   // Reset values.
   localparam logic [7:0] TIMEOUT_RST = 8'h04;
   localparam logic [2:0] DIVISOR_RST = 3'h0;

   // Timing: the clock period and the figures derived from it.
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SECOND_NS       = 1000000000;
   localparam int SEC_CYCLES      = SECOND_NS / CLK_PERIOD_NS;
   localparam int SYS_RESET_US    = 1000;
   localparam int SYS_RESET_CYC   = (SYS_RESET_US * 1000) / CLK_PERIOD_NS;
   localparam int BITS_PER_XFER   = 8;
   localparam int EDGES_PER_XFER  = 2 * BITS_PER_XFER;

   // Serial control register layout.
   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic       done_irq_enable;
      logic       controller_select;
      logic       clock_idle_level;
      logic       clock_edge_phase;
      logic       rsvd_lo;
      logic       low_bit_first;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   // Serial engine states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_END   = 3'b100
   } xfer_state_t;

endpackage

/* spi_cfg_ctrl.sv */
// Purpose: Configuration, status, fallback timer and byte shifter of a serial boot flash controller.
// Assumes: Register port is same-domain; strap and pin inputs are asynchronous and synchronised.
// Notes:   The serial clock is produced here from ref_clk by a divider.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps

// Function
// - Control bit 5 enables the transfer-done interrupt; resets to zero.
// - Control bit 4 enables controller operation; cleared disables the interface; resets one.
// - Control bit 3 picks serial clock idle level: one idles high.
// - Control bit 2 set drives data on the first clock edge and samples on the second, else samples on the first.
// - Control bit 0 set shifts least significant bit first, else most significant first.
// - Eight-bit timeout, reset four, seconds before hub-disable in backup use.
// - Three-bit divisor code sets serial clock rate; zero is the fastest rate.
// - Status bit 7 sets when a transfer completes; only a written one clears it.
// - Backup use: status bit 6 sets when seconds reach timeout; written one clears.
// - Primary use: the hub-disable status bit always reads one.
// - Status bit 5 is read-only and mirrors the interface enable.
// - Primary use: status bit 4 sets when seconds reach timeout; written one clears.
// - Primary timeout asserts system reset and selects the second flash if enabled, else the upper half.
// - Busy status bit is one while a transfer runs, clears itself at its end.
module spi_cfg_ctrl
   import spi_cfg_pkg::*;
#(
   parameter int SEC_COUNT   = SEC_CYCLES,
   parameter int RESET_COUNT = SYS_RESET_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       primary_mode,
   input  wire logic       iface_enable,
   input  wire logic       second_select_enable,
   input  wire logic       serial_in,
   output logic            serial_clk,
   output logic            serial_out,
   output logic            busy,
   output logic            irq,
   output logic            hub_disable,
   output logic            sys_reset,
   output logic            second_cs,
   output logic            upper_half
);

   // Reset release synchroniser.
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // Two-stage synchronisers for the pin and strap inputs.
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= {primary_mode, iface_enable, second_select_enable, serial_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   logic primary_s;
   logic enable_s;
   logic sel_en_s;
   logic miso_s;

   assign primary_s = pin_s2_q[3];
   assign enable_s  = pin_s2_q[2];
   assign sel_en_s  = pin_s2_q[1];
   assign miso_s    = pin_s2_q[0];

   // Decoded register strobes.
   logic wr_ctrl;
   logic wr_tmo;
   logic wr_div;
   logic wr_stat;
   logic wr_tx;
   logic wr_evc;
   logic wr_eve;

   assign wr_ctrl = wr_en && (addr == OFF_CONTROL);
   assign wr_tmo  = wr_en && (addr == OFF_TIMEOUT);
   assign wr_div  = wr_en && (addr == OFF_DIVISOR);
   assign wr_stat = wr_en && (addr == OFF_STATUS);
   assign wr_tx   = wr_en && (addr == OFF_TX_DATA);
   assign wr_evc  = wr_en && (addr == OFF_EV_CLEAR);
   assign wr_eve  = wr_en && (addr == OFF_EV_EN);

   // Configuration registers.
   ctrl_t      ctrl_q;
   logic [7:0] fallback_seconds_q;
   logic [2:0] clock_divider_code_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q               <= CTRL_RST;
         fallback_seconds_q   <= TIMEOUT_RST;
         clock_divider_code_q <= DIVISOR_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q          <= wr_data;
            ctrl_q.rsvd_hi  <= 2'h0;
            ctrl_q.rsvd_lo  <= 1'b0;
         end
         if (wr_tmo) begin
            fallback_seconds_q <= wr_data;
         end
         if (wr_div) begin
            clock_divider_code_q <= wr_data[2:0];
         end
      end
   end

   // Serial engine state.
   xfer_state_t state_q;
   logic [7:0]  tx_q;
   logic [7:0]  rx_q;
   logic [7:0]  rx_data_q;
   logic [4:0]  edge_cnt_q;
   logic [2:0]  half_cnt_q;
   logic        sck_q;
   logic        mosi_q;
   logic        done_pulse_q;
   logic        tick;
   logic [2:0]  bit_idx;
   logic [2:0]  bit_pos;
   logic        start;

   // A write to the transmit register starts a byte, only while the controller is selected.
   assign start   = wr_tx && ctrl_q.controller_select && (state_q == ST_IDLE);
   // One half period is divisor code plus one ref_clk cycles.
   assign tick    = (half_cnt_q == clock_divider_code_q);
   assign bit_idx = edge_cnt_q[3:1];
   // Bit order maps the running index onto the byte.
   assign bit_pos = ctrl_q.low_bit_first ? bit_idx : 3'(7 - bit_idx);

   // Half-period divider, held cleared outside a transfer.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt_q <= 3'h0;
      end else if (state_q != ST_SHIFT || tick) begin
         half_cnt_q <= 3'h0;
      end else begin
         half_cnt_q <= half_cnt_q + 3'h1;
      end
   end

   // Transfer sequencing, clock and data lines.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= ST_IDLE;
         tx_q         <= 8'h00;
         rx_q         <= 8'h00;
         rx_data_q    <= 8'h00;
         edge_cnt_q   <= 5'h0;
         sck_q        <= 1'b0;
         mosi_q       <= 1'b0;
         done_pulse_q <= 1'b0;
      end else begin
         done_pulse_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               sck_q <= ctrl_q.clock_idle_level;
               if (start) begin
                  tx_q       <= wr_data;
                  edge_cnt_q <= 5'h0;
                  state_q    <= ST_SHIFT;
                  if (!ctrl_q.clock_edge_phase) begin
                     // Data leads the first edge by half a period.
                     mosi_q <= ctrl_q.low_bit_first ? wr_data[0] : wr_data[7];
                  end
               end
            end
            ST_SHIFT: begin
               if (!ctrl_q.controller_select) begin
                  state_q <= ST_IDLE;
               end else if (tick) begin
                  sck_q      <= ~sck_q;
                  edge_cnt_q <= edge_cnt_q + 5'h1;
                  if (edge_cnt_q[0] == ctrl_q.clock_edge_phase) begin
                     rx_q[bit_pos] <= miso_s;
                  end else if (ctrl_q.clock_edge_phase) begin
                     mosi_q <= tx_q[bit_pos];
                  end else if (bit_idx != 3'h7) begin
                     mosi_q <= tx_q[ctrl_q.low_bit_first ? 3'(bit_pos + 3'h1)
                                                         : 3'(bit_pos - 3'h1)];
                  end
                  if (edge_cnt_q == 5'(EDGES_PER_XFER - 1)) begin
                     state_q <= ST_END;
                  end
               end
            end
            ST_END: begin
               rx_data_q    <= rx_q;
               done_pulse_q <= 1'b1;
               sck_q        <= ctrl_q.clock_idle_level;
               state_q      <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Seconds timebase and elapsed-seconds count, restarted by a timeout write.
   logic [31:0] sub_cnt_q;
   logic [7:0]  elapsed_q;
   logic        fired_q;
   logic        expire;

   assign expire = !fired_q && (elapsed_q >= fallback_seconds_q);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt_q <= 32'h0;
         elapsed_q <= 8'h00;
         fired_q   <= 1'b0;
      end else if (wr_tmo) begin
         sub_cnt_q <= 32'h0;
         elapsed_q <= 8'h00;
         fired_q   <= 1'b0;
      end else begin
         if (expire) begin
            fired_q <= 1'b1;
         end
         if (!fired_q) begin
            if (sub_cnt_q == 32'(SEC_COUNT - 1)) begin
               sub_cnt_q <= 32'h0;
               elapsed_q <= elapsed_q + 8'h01;
            end else begin
               sub_cnt_q <= sub_cnt_q + 32'h1;
            end
         end
      end
   end

   // Sticky status flags; a new event wins over a clear in the same cycle.
   logic done_flag_q;
   logic hub_flag_q;
   logic primary_flag_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_flag_q    <= 1'b0;
         hub_flag_q     <= 1'b0;
         primary_flag_q <= 1'b0;
      end else begin
         if (done_pulse_q) begin
            done_flag_q <= 1'b1;
         end else if (wr_stat && wr_data[ST_DONE]) begin
            done_flag_q <= 1'b0;
         end
         if (expire && !primary_s) begin
            hub_flag_q <= 1'b1;
         end else if (wr_stat && wr_data[ST_HUB]) begin
            hub_flag_q <= 1'b0;
         end
         if (expire && primary_s) begin
            primary_flag_q <= 1'b1;
         end else if (wr_stat && wr_data[ST_PRIMARY]) begin
            primary_flag_q <= 1'b0;
         end
      end
   end

   // System reset pulse and second-flash steering on a primary timeout.
   logic [31:0] rst_cnt_q;
   logic        sys_reset_q;
   logic        second_cs_q;
   logic        upper_half_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cnt_q    <= 32'h0;
         sys_reset_q  <= 1'b0;
         second_cs_q  <= 1'b0;
         upper_half_q <= 1'b0;
      end else if (expire && primary_s) begin
         rst_cnt_q    <= 32'(RESET_COUNT - 1);
         sys_reset_q  <= 1'b1;
         second_cs_q  <= sel_en_s;
         upper_half_q <= !sel_en_s;
      end else if (rst_cnt_q != 32'h0) begin
         rst_cnt_q <= rst_cnt_q - 32'h1;
      end else begin
         sys_reset_q <= 1'b0;
      end
   end

   // Event status, enable and interrupt line.
   logic [EV_W-1:0] ev_stat_q;
   logic [EV_W-1:0] ev_en_q;
   logic [EV_W-1:0] ev_set;
   logic            irq_q;

   assign ev_set = {expire && primary_s, expire && !primary_s, done_pulse_q};

   genvar g;
   generate
      for (g = 0; g < EV_W; g++) begin : g_ev
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               ev_stat_q[g] <= 1'b0;
            end else if (ev_set[g]) begin
               ev_stat_q[g] <= 1'b1;
            end else if (wr_evc && wr_data[g]) begin
               ev_stat_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_en_q <= '0;
         irq_q   <= 1'b0;
      end else begin
         if (wr_eve) begin
            ev_en_q <= wr_data[EV_W-1:0];
         end
         irq_q <= (done_flag_q && ctrl_q.done_irq_enable)
                  || ((ev_stat_q & ev_en_q) != '0);
      end
   end

   // Read data, valid in the cycle after the read strobe.
   logic [7:0] status_v;
   logic [7:0] rd_q;
   logic       busy_q;
   logic       hub_q;

   always_comb begin
      status_v              = 8'h00;
      status_v[ST_DONE]     = done_flag_q;
      status_v[ST_HUB]      = primary_s ? 1'b1 : hub_flag_q;
      status_v[ST_ENABLE]   = enable_s;
      status_v[ST_PRIMARY]  = primary_flag_q;
      status_v[ST_BUSY]     = busy_q;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            OFF_CONTROL: rd_q <= ctrl_q;
            OFF_TIMEOUT: rd_q <= fallback_seconds_q;
            OFF_DIVISOR: rd_q <= {5'h00, clock_divider_code_q};
            OFF_STATUS:  rd_q <= status_v;
            OFF_TX_DATA: rd_q <= tx_q;
            OFF_RX_DATA: rd_q <= rx_data_q;
            OFF_EV_STAT: rd_q <= {5'h00, ev_stat_q};
            OFF_EV_EN:   rd_q <= {5'h00, ev_en_q};
            default:     rd_q <= 8'h00;
         endcase
      end else begin
         rd_q <= 8'h00;
      end
   end

   // Busy and hub-disable pins follow the engine and the flags.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         hub_q  <= 1'b0;
      end else begin
         busy_q <= start || (state_q == ST_SHIFT);
         hub_q  <= primary_s || hub_flag_q;
      end
   end

   assign rd_data     = rd_q;
   assign serial_clk  = sck_q;
   assign serial_out  = mosi_q;
   assign busy        = busy_q;
   assign irq         = irq_q;
   assign hub_disable = hub_q;
   assign sys_reset   = sys_reset_q;
   assign second_cs   = second_cs_q;
   assign upper_half  = upper_half_q;

endmodule

/* spi_cfg_properties.sv */
// Purpose: Port assertions for the serial flash configuration block.
// Assumes: Straps are held steady for a few cycles around the checks.
// Notes:   Shadows of the writable registers follow the write strobe.
`timescale 1ns/100ps
module spi_cfg_props
   import spi_cfg_pkg::*;
#(
   parameter int SEC_COUNT   = SEC_CYCLES,
   parameter int RESET_COUNT = SYS_RESET_CYC
) (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   input wire logic       primary_mode,
   input wire logic       iface_enable,
   input wire logic       second_select_enable,
   input wire logic       serial_in,
   input wire logic       serial_clk,
   input wire logic       serial_out,
   input wire logic       busy,
   input wire logic       irq,
   input wire logic       hub_disable,
   input wire logic       sys_reset,
   input wire logic       second_cs,
   input wire logic       upper_half
);
   logic [7:0] ctrl_q;
   logic [7:0] tout_q;
   logic [2:0] div_q;
   logic [7:0] ev_en_q;
   int         busy_cnt_q;
   int         rst_cnt_q;
   int         idle_cnt_q;
   // Shadow copies of the writable registers.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q  <= 8'h10;
         tout_q  <= 8'h04;
         div_q   <= 3'h0;
         ev_en_q <= 8'h00;
      end else if (wr_en) begin
         if (addr == OFF_CONTROL) ctrl_q <= wr_data;
         if (addr == OFF_TIMEOUT) tout_q <= wr_data;
         if (addr == OFF_DIVISOR) div_q <= wr_data[2:0];
         if (addr == OFF_EV_EN) ev_en_q <= wr_data;
      end
   end
   // Lengths of busy and reset pulses, and quiet time of the serial clock.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_q <= 0;
         rst_cnt_q  <= 0;
         idle_cnt_q <= 0;
      end else begin
         busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
         rst_cnt_q  <= sys_reset ? rst_cnt_q + 1 : 0;
         idle_cnt_q <= (busy || (wr_en && (addr == OFF_CONTROL || addr == OFF_TX_DATA)))
                       ? 0 : idle_cnt_q + 1;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_read(logic [7:0] a);
      rd_en && addr == a;
   endsequence
   property p_ctrl_rd;
      s_read(OFF_CONTROL) |=> (rd_data & 8'h3D) == ($past(ctrl_q) & 8'h3D);
   endproperty
   property p_tout_rd;
      s_read(OFF_TIMEOUT) |=> rd_data == $past(tout_q);
   endproperty
   property p_div_rd;
      s_read(OFF_DIVISOR) |=> rd_data[2:0] == $past(div_q);
   endproperty
   property p_mirror;
      ($stable(iface_enable) [*4] ##0 s_read(OFF_STATUS)) |=> rd_data[5] == $past(iface_enable);
   endproperty
   property p_hub_prim;
      ($stable(primary_mode) [*4] ##0 primary_mode ##0 s_read(OFF_STATUS)) |=> rd_data[6];
   endproperty
   property p_busy_len;
      $fell(busy) && ctrl_q[4] |-> busy_cnt_q >= 16 * (div_q + 1)
                                   && busy_cnt_q <= 16 * (div_q + 1) + 3;
   endproperty
   property p_done_irq;
      $fell(busy) && ctrl_q[5] && ctrl_q[4] |-> ##[1:4] irq;
   endproperty
   property p_irq_off;
      (!ctrl_q[5] && ev_en_q == 8'h00) [*3] |-> !irq;
   endproperty
   property p_idle_clk;
      idle_cnt_q > 4 |-> serial_clk == ctrl_q[3];
   endproperty
   property p_sys_len;
      $fell(sys_reset) |-> rst_cnt_q == RESET_COUNT;
   endproperty
   property p_sel;
      $rose(sys_reset) |-> ##[0:2] (second_cs == second_select_enable
                                    && upper_half != second_select_enable);
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("control readback wrong");
   a_tout_rd: assert property (p_tout_rd)
      else $error("timeout readback wrong");
   a_div_rd: assert property (p_div_rd)
      else $error("divider readback wrong");
   a_mirror: assert property (p_mirror)
      else $error("enable mirror wrong");
   a_hub_prim: assert property (p_hub_prim)
      else $error("hub flag not one in primary use");
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");
   a_done_irq: assert property (p_done_irq)
      else $error("no interrupt after transfer");
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt while disabled");
   a_idle_clk: assert property (p_idle_clk)
      else $error("serial clock not at idle level");
   a_sys_len: assert property (p_sys_len)
      else $error("system reset length wrong");
   a_sel: assert property (p_sel)
      else $error("second flash selection wrong");
endmodule

bind spi_cfg_ctrl spi_cfg_props #(
   .SEC_COUNT  (SEC_COUNT),
   .RESET_COUNT(RESET_COUNT)
) props_i (.*);

/* flash_model.sv */
// Purpose: Behavioural serial flash that answers a fixed byte.
// Assumes: A clr pulse opens each one-byte frame; phase picks the sampling edge.
// Notes:   Reports the captured byte, the edge count and the edge span in cycles.
`timescale 1ns/100ps
module flash_model #(
   parameter logic [7:0] REPLY = 8'hA5
) (
   input  wire logic       ref_clk,
   input  wire logic       clr,
   input  wire logic       phase,
   input  wire logic       serial_clk,
   input  wire logic       serial_out,
   output logic            serial_in,
   output logic      [7:0] cap,
   output int              edges,
   output int              span
);
   int tick;
   int t1;
   int idx;
   // Cycle count used to time the serial clock edges.
   always @(posedge ref_clk) tick <= tick + 1;
   initial serial_in = 1'b0;
   // Samples on one edge kind and shifts the reply on the other.
   always @(serial_clk or posedge clr) begin
      if (clr) begin
         edges = 0;
         idx = phase ? 8 : 7;
         serial_in = phase ? ~REPLY[7] : REPLY[7];
      end else begin
         edges = edges + 1;
         if (edges == 1) t1 = tick;
         span = tick - t1;
         if ((edges % 2 == 1) != phase) cap = {cap[6:0], serial_out};
         else if (idx > 0) begin
            idx = idx - 1;
            serial_in = REPLY[idx];
         end else serial_in = ~serial_in; // Released line no longer holds the last bit.
      end
   end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the serial flash configuration block.
// Assumes: Short second and reset counts keep the run brief.
// Notes:   Expected values come from the register layout and the timing note.
`timescale 1ns/100ps
module tb;
   import spi_cfg_pkg::*;
   localparam int SECS = 20;
   localparam int RSTC = 5;
   typedef struct packed {logic [7:0] c; logic [2:0] d; logic [7:0] t;} cfg_t;
   logic       ref_clk = 1'b0;
   logic       resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       primary_mode = 1'b0;
   logic       iface_enable = 1'b1;
   logic       sel = 1'b0;
   logic       clr = 1'b0;
   logic       phase = 1'b0;
   logic [7:0] rd_data, cap;
   logic       serial_in, serial_clk, serial_out, busy, irq;
   logic       hub_disable, sys_reset, second_cs, upper_half;
   int         edges, span;
   int         bad_count = 0;
   int         comparisons = 0;
   cfg_t       cfgs [5] = '{'{8'h30, 3'h0, 8'h96}, '{8'h39, 3'h1, 8'h1E},
                            '{8'h38, 3'h3, 8'h6B}, '{8'h3D, 3'h7, 8'hF1},
                            '{8'h14, 3'h2, 8'h80}};
   spi_cfg_ctrl #(.SEC_COUNT(SECS), .RESET_COUNT(RSTC)) uut (.second_select_enable(sel), .*);
   flash_model #(.REPLY(8'hC5)) fm (.*);
   // Clock of 100 ns period.
   always #50 ref_clk = ~ref_clk;
   task automatic chk(string name, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", name, e, g);
         bad_count++;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge ref_clk);
      wr_en   <= 1'b0;
   endtask
   task automatic rdc(logic [7:0] a, logic [7:0] m, logic [7:0] e, string name);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #10;
      chk(name, e, rd_data & m);
   endtask
   task automatic wait_sig(ref logic s, input logic v, input string name);
      int n = 0;
      while (s !== v && n < 2000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(name, 8'(v), 8'(s));
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog cuts a hung run short.
   initial begin
      #2000000;
      bad_count++;
      print_verdict();
   end
   // Main sequence of tests.
   initial begin
      cfg_t cf;
      logic [7:0] rev;
      int n;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(OFF_CONTROL, 8'h3D, 8'h10, "control reset");
      rdc(OFF_TIMEOUT, 8'hFF, 8'h04, "timeout reset");
      rdc(OFF_DIVISOR, 8'h07, 8'h00, "divider reset");
      rdc(OFF_STATUS, 8'hF8, 8'h20, "status reset");
      rdc(8'h55, 8'hFF, 8'h00, "unmapped");
      rdc(OFF_EV_CLEAR, 8'hFF, 8'h00, "clear reads zero");
      wr(OFF_TIMEOUT, 8'hC7);
      rdc(OFF_TIMEOUT, 8'hFF, 8'hC7, "timeout rw");
      wr(OFF_DIVISOR, 8'h05);
      rdc(OFF_DIVISOR, 8'h07, 8'h05, "divider rw");
      wr(OFF_CONTROL, 8'h2D);
      rdc(OFF_CONTROL, 8'h3D, 8'h2D, "control rw");
      $display("register test done");
      for (int i = 0; i < 5; i++) begin
         cf = cfgs[i];
         rev = {<<{cf.t}};
         wr(OFF_CONTROL, cf.c);
         wr(OFF_DIVISOR, {5'h00, cf.d});
         phase <= cf.c[2];
         clr   <= 1'b1;
         @(posedge ref_clk);
         clr   <= 1'b0;
         wr(OFF_TX_DATA, cf.t);
         repeat (3) @(posedge ref_clk);
         #1 chk("busy", 8'h01, 8'(busy));
         wait_sig(busy, 1'b0, "busy end");
         chk("edges", 8'd16, 8'(edges));
         chk("span", 8'(15 * (cf.d + 1)), 8'(span));
         chk("sent", cf.c[0] ? rev : cf.t, cap);
         rdc(OFF_STATUS, 8'hB8, 8'hA0, "status done");
         chk("idle clock", 8'(cf.c[3]), 8'(serial_clk));
         chk("irq", 8'(cf.c[5]), 8'(irq));
         wr(OFF_STATUS, 8'h00);
         rdc(OFF_STATUS, 8'h80, 8'h80, "done kept");
         if (cf.d > 2) rdc(OFF_RX_DATA, 8'hFF, cf.c[0] ? 8'hA3 : 8'hC5, "received");
         wr(OFF_STATUS, 8'h80);
         rdc(OFF_STATUS, 8'h80, 8'h00, "done cleared");
         chk("irq off", 8'h00, 8'(irq));
         $display("transfer test %0d done", i);
      end
      wr(OFF_CONTROL, 8'h00);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      wr(OFF_TX_DATA, 8'h55);
      repeat (4) @(posedge ref_clk);
      #1 chk("refused busy", 8'h00, 8'(busy));
      chk("refused edges", 8'h00, 8'(edges));
      wr(OFF_CONTROL, 8'h10);
      iface_enable <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdc(OFF_STATUS, 8'h20, 8'h00, "mirror off");
      @(posedge ref_clk) iface_enable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdc(OFF_STATUS, 8'h20, 8'h20, "mirror on");
      $display("enable test done");
      wr(OFF_STATUS, 8'h40);
      wr(OFF_EV_CLEAR, 8'h07);
      wr(OFF_TIMEOUT, 8'h02);
      repeat (20) @(posedge ref_clk);
      rdc(OFF_STATUS, 8'h40, 8'h00, "hub early");
      repeat (30) @(posedge ref_clk);
      rdc(OFF_STATUS, 8'h40, 8'h40, "hub set");
      chk("hub pin", 8'h01, 8'(hub_disable));
      rdc(OFF_EV_STAT, 8'h02, 8'h02, "hub event");
      wr(OFF_EV_EN, 8'h02);
      @(posedge ref_clk);
      #1 chk("event irq", 8'h01, 8'(irq));
      wr(OFF_EV_EN, 8'h00);
      @(posedge ref_clk);
      #1 chk("masked irq", 8'h00, 8'(irq));
      wr(OFF_EV_CLEAR, 8'h02);
      rdc(OFF_EV_STAT, 8'hFF, 8'h00, "event cleared");
      wr(OFF_STATUS, 8'h40);
      rdc(OFF_STATUS, 8'h40, 8'h00, "hub cleared");
      chk("hub pin off", 8'h00, 8'(hub_disable));
      $display("backup timeout test done");
      @(posedge ref_clk) primary_mode <= 1'b1;
      for (int s = 1; s >= 0; s--) begin
         @(posedge ref_clk) sel <= 1'(s);
         wr(OFF_TIMEOUT, 8'h01);
         rdc(OFF_STATUS, 8'h40, 8'h40, "hub primary");
         wait_sig(sys_reset, 1'b1, "reset start");
         n = 0;
         while (sys_reset === 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         chk("reset length", 8'(RSTC), 8'(n));
         chk("second cs", 8'(s), 8'(second_cs));
         chk("upper half", 8'(1 - s), 8'(upper_half));
         chk("hub pin primary", 8'h01, 8'(hub_disable));
         rdc(OFF_STATUS, 8'h10, 8'h10, "primary flag");
         wr(OFF_STATUS, 8'h50);
         rdc(OFF_STATUS, 8'h50, 8'h40, "primary cleared");
      end
      $display("primary timeout test done");
      print_verdict();
   end
endmodule
